// File: rtl/uaxt_tx_dev.sv
// Purpose: transmit half of an asynchronous serial port, register port on the user side
// Assumes: ref_clk_i is the bus clock, rx_data_i from a local receiver
// Notes: baud tick is one per bit time
// Summary of operation
// - data address: read receive, write transmit
// - data accesses join flag clearing sequences
// - bus clock baud generator shared with receiver
// - inversion applies to every output case
// - idle high; inversion cleared by reset
// - enabling queues one idle preamble frame
// - shifter 10 bits, 11 in nine-bit mode
// - start 0, data LSB first, stop 1
// - ninth bit above MSB, captured on write
// - load on baud tick, set buffer empty
// - nothing waiting after stop: done, idle high
// - disabling holds pin until shifter and break/idle queues drain; a full buffer waits for enable
// - break request 1 then 0 queues break
// - request still set at load: queue another
// - break all zero, 10/11/13/14 bit times
// - enable 0 then 1 queues idle character
// - pin held while shifter busy
// - software waits buffer empty before queuing
// - software sets pin high if released
`timescale 1ns/1ps
`include "uaxt_cfg.svh"
module uaxt_tx_dev
  import uaxt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  uaxt_link_if.dev link,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rx_data_i,
  output logic [7:0] rdata_o,
  output logic rx_data_read_o,
  output logic baud_tick_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] frame_len(input logic nine, input logic brk,
                                           input logic lbrk);
    logic [3:0] len;
    len = nine ? `UAXT_LEN_9 : `UAXT_LEN_8;
    if (brk && lbrk) begin
      len = len + `UAXT_LEN_LBRK;
    end
    return len;
  endfunction : frame_len

  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  uaxt_div_t div_r;
  uaxt_div_t baud_cnt_r;
  uaxt_tx_state_e st_r;
  logic [10:0] sreg_r;
  logic fill_r;
  logic [3:0] bits_left_r;
  logic [8:0] tdata_r;
  logic empty_r;
  logic done_r;
  logic done_armed_r;
  logic brk_q_r;
  logic idle_q_r;
  logic txd_r;
  logic oe_r;
  logic [7:0] rdata_r;
  logic rx_rd_r;

  logic tick;
  logic wr_data;
  logic wr_ctrl;
  logic rd_stat;
  logic tx_on;
  logic nine;
  logic free;
  logic ld_brk;
  logic ld_idle;
  logic ld_data;
  logic finish;

  assign wr_data = wr_i && (addr_i == `UAXT_ADDR_DATA);
  assign wr_ctrl = wr_i && (addr_i == `UAXT_ADDR_CTRL);
  assign rd_stat = rd_i && (addr_i == `UAXT_ADDR_STAT);
  assign tx_on = ctrl_r[`UAXT_CTRL_TXON];
  assign nine = ctrl_r[`UAXT_CTRL_NINE];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `UAXT_CTRL_RST;
      cfg_r <= `UAXT_CFG_RST;
      div_r <= `UAXT_DIV_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        `UAXT_ADDR_CTRL: ctrl_r <= wdata_i;
        `UAXT_ADDR_CFG: cfg_r <= wdata_i;
        `UAXT_ADDR_DIVH: div_r[12:8] <= wdata_i[4:0];
        `UAXT_ADDR_DIVL: div_r[7:0] <= wdata_i;
        default: ;
      endcase
    end
  end

  // reads answer one cycle later; unmapped reads give zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      rx_rd_r <= 1'b0;
    end else begin
      rx_rd_r <= rd_i && (addr_i == `UAXT_ADDR_DATA);
      rdata_r <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          `UAXT_ADDR_DATA: rdata_r <= rx_data_i;
          `UAXT_ADDR_STAT: rdata_r <= {empty_r, done_r, 5'h00, st_r == ST_SHIFT};
          `UAXT_ADDR_CTRL: rdata_r <= ctrl_r;
          `UAXT_ADDR_CFG: rdata_r <= cfg_r;
          `UAXT_ADDR_DIVH: rdata_r <= {3'h0, div_r[12:8]};
          `UAXT_ADDR_DIVL: rdata_r <= div_r[7:0];
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // a divisor of zero stops the generator, freezing the shifter
  assign tick = (div_r != 13'h0000) && (baud_cnt_r == div_r - 13'h0001);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_cnt_r <= 13'h0000;
    end else if (tick || (baud_cnt_r >= div_r)) begin
      baud_cnt_r <= 13'h0000;
    end else begin
      baud_cnt_r <= baud_cnt_r + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // load decision
  // ----------------------------------------------------------------
  // queued break goes first, then idle, then data
  assign free = tick && ((st_r == ST_IDLE) || (bits_left_r == 4'h1));
  assign ld_brk = free && brk_q_r;
  assign ld_idle = free && !brk_q_r && idle_q_r;
  assign ld_data = free && !brk_q_r && !idle_q_r && tx_on && !empty_r;
  assign finish = free && (st_r == ST_SHIFT) && !ld_brk && !ld_idle && !ld_data;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      sreg_r <= 11'h7FF;
      fill_r <= 1'b1;
      bits_left_r <= 4'h0;
    end else if (ld_brk) begin
      st_r <= ST_SHIFT;
      sreg_r <= 11'h000;
      fill_r <= 1'b0;
      bits_left_r <= frame_len(nine, 1'b1, ctrl_r[`UAXT_CTRL_LBRK]);
    end else if (ld_idle) begin
      st_r <= ST_SHIFT;
      sreg_r <= 11'h7FF;
      fill_r <= 1'b1;
      bits_left_r <= frame_len(nine, 1'b0, 1'b0);
    end else if (ld_data) begin
      st_r <= ST_SHIFT;
      fill_r <= 1'b1;
      bits_left_r <= frame_len(nine, 1'b0, 1'b0);
      if (nine) begin
        sreg_r <= {1'b1, tdata_r, 1'b0};
      end else begin
        sreg_r <= {2'h3, tdata_r[7:0], 1'b0};
      end
    end else if (finish) begin
      st_r <= ST_IDLE;
      sreg_r <= 11'h7FF;
      fill_r <= 1'b1;
      bits_left_r <= 4'h0;
    end else if (tick && (st_r == ST_SHIFT)) begin
      sreg_r <= {fill_r, sreg_r[10:1]};
      bits_left_r <= bits_left_r - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // buffer, flags and queues
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tdata_r <= 9'h000;
    end else if (wr_data) begin
      tdata_r <= {cfg_r[`UAXT_CFG_NINTH], wdata_i};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      empty_r <= 1'b1;
    end else if (ld_data) begin
      empty_r <= 1'b1;
    end else if (wr_data) begin
      empty_r <= 1'b0;
    end
  end

  // done clears by a status read seeing it set, then a data write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_r <= 1'b1;
      done_armed_r <= 1'b0;
    end else begin
      if (finish) begin
        done_r <= 1'b1;
      end else if ((wr_data && done_armed_r) || ld_brk || ld_idle) begin
        done_r <= 1'b0;
      end
      if (wr_data || finish) begin
        done_armed_r <= 1'b0;
      end else if (rd_stat && done_r) begin
        done_armed_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_q_r <= 1'b0;
    end else if (wr_ctrl && ctrl_r[`UAXT_CTRL_BRK] && !wdata_i[`UAXT_CTRL_BRK]) begin
      brk_q_r <= 1'b1;
    end else if (ld_brk && ctrl_r[`UAXT_CTRL_BRK]) begin
      brk_q_r <= 1'b1;
    end else if (ld_brk) begin
      brk_q_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q_r <= 1'b0;
    end else if (wr_ctrl && !tx_on && wdata_i[`UAXT_CTRL_TXON]) begin
      idle_q_r <= 1'b1;
    end else if (ld_idle) begin
      idle_q_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // one flop stage keeps the pin glitch free; adds a cycle of lag
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      txd_r <= sreg_r[0] ^ cfg_r[`UAXT_CFG_INV];
      oe_r <= tx_on || (st_r == ST_SHIFT) || brk_q_r || idle_q_r;
    end
  end

  assign link.txd = txd_r;
  assign link.txd_oe = oe_r;
  assign rdata_o = rdata_r;
  assign rx_data_read_o = rx_rd_r;
  assign baud_tick_o = tick;
endmodule : uaxt_tx_dev

// File: rtl/uaxt_cfg.svh
// Purpose: offsets, field positions, reset values and frame lengths
// Assumes: byte-wide register port, 3-bit address
// Notes: definitions only
`ifndef UAXT_CFG_SVH
`define UAXT_CFG_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UAXT_ADDR_DATA 3'h0
`define UAXT_ADDR_STAT 3'h1
`define UAXT_ADDR_CTRL 3'h2
`define UAXT_ADDR_CFG 3'h3
`define UAXT_ADDR_DIVH 3'h4
`define UAXT_ADDR_DIVL 3'h5
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UAXT_STAT_EMPTY 7
`define UAXT_STAT_DONE 6
`define UAXT_STAT_BUSY 0
`define UAXT_CTRL_NINE 4
`define UAXT_CTRL_TXON 3
`define UAXT_CTRL_LBRK 2
`define UAXT_CTRL_BRK 0
`define UAXT_CFG_NINTH 6
`define UAXT_CFG_INV 4
// ----------------------------------------------------------------
// reset values and lengths
// ----------------------------------------------------------------
`define UAXT_CTRL_RST 8'h00
`define UAXT_CFG_RST 8'h00
`define UAXT_DIV_RST 13'h0000
`define UAXT_LEN_8 4'hA
`define UAXT_LEN_9 4'hB
`define UAXT_LEN_LBRK 4'h3
`endif

// File: rtl/uaxt_pkg.sv
// Purpose: shared types of the serial transmitter pair
// Assumes: uaxt_cfg.svh holds the numbers
// Notes: none
package uaxt_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} uaxt_tx_state_e;
  typedef enum logic [0:0] {RS_IDLE, RS_RUN} uaxt_rx_state_e;
  typedef logic [12:0] uaxt_div_t;
endpackage : uaxt_pkg

// File: rtl/uaxt_link_if.sv
// Purpose: serial line between transmitter and remote receiver
// Assumes: one-way pin, driven only by the transmitter
// Notes: txd_oe low means the pin is released
`timescale 1ns/1ps
interface uaxt_link_if;
  logic txd;
  logic txd_oe;
  modport dev (output txd, output txd_oe);
  modport rmt (input txd, input txd_oe);
endinterface : uaxt_link_if

// File: rtl/uaxt_rx_rmt.sv
// Purpose: remote serial receiver at the far end of the line
// Assumes: same bus clock rate and divisor as the transmitter
// Notes: released pin reads as idle
`timescale 1ns/1ps
`include "uaxt_cfg.svh"
module uaxt_rx_rmt
  import uaxt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  uaxt_link_if.rmt link,
  input wire logic [12:0] div_i,
  input wire logic nine_i,
  input wire logic invert_i,
  output logic [8:0] data_o,
  output logic valid_o,
  output logic framing_error_flag_o,
  output logic break_o
);
  // ----------------------------------------------------------------
  // line sync
  // ----------------------------------------------------------------
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  uaxt_rx_state_e st_r;
  uaxt_div_t cnt_r;
  logic [3:0] idx_r;
  logic [9:0] sh_r;
  logic [8:0] data_r;
  logic valid_r;
  logic ferr_r;
  logic brk_r;
  logic line;
  logic [3:0] last;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      sync1_r <= link.txd_oe ? link.txd ^ invert_i : 1'b1;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign line = sync2_r;
  assign last = nine_i ? `UAXT_LEN_9 - 4'h1 : `UAXT_LEN_8 - 4'h1;

  // ----------------------------------------------------------------
  // frame checker
  // ----------------------------------------------------------------
  // samples div_i/2 + 1 clocks into each bit, the last clock at divisor 4; no noise filter, single sample per bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= RS_IDLE;
      cnt_r <= 13'h0000;
      idx_r <= 4'h0;
      sh_r <= 10'h000;
      data_r <= 9'h000;
      valid_r <= 1'b0;
      ferr_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      unique case (st_r)
        RS_IDLE: begin
          if (prev_r && !line && (div_i != 13'h0000)) begin
            st_r <= RS_RUN;
            cnt_r <= {1'b0, div_i[12:1]};
            idx_r <= 4'h0;
          end
        end
        RS_RUN: begin
          if (cnt_r != 13'h0000) begin
            cnt_r <= cnt_r - 13'h0001;
          end else begin
            cnt_r <= div_i - 13'h0001;
            if (idx_r == 4'h0 && line) begin
              st_r <= RS_IDLE;
            end else if (idx_r == last) begin
              st_r <= RS_IDLE;
              valid_r <= 1'b1;
              ferr_r <= !line;
              brk_r <= !line && (sh_r == 10'h000);
              data_r <= nine_i ? sh_r[9:1] : {1'b0, sh_r[9:2]};
            end else begin
              idx_r <= idx_r + 4'h1;
              if (idx_r != 4'h0) begin
                sh_r <= {line, sh_r[9:1]};
              end else begin
                sh_r <= 10'h000;
              end
            end
          end
        end
      endcase
    end
  end

  assign data_o = data_r;
  assign valid_o = valid_r;
  assign framing_error_flag_o = ferr_r;
  assign break_o = brk_r;
endmodule : uaxt_rx_rmt

// File: tb/uaxt_link_assertions.sv
// Purpose: line and port checks for the serial transmitter pair
// Assumes: divisor 4 written once, inversion changed only while idle
// Notes: inversion shadow is rebuilt from the write port
`timescale 1ns/1ps
`include "uaxt_cfg.svh"
module uaxt_link_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic txd_i,
  input wire logic txd_oe_i,
  input wire logic baud_tick_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_i
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic inv_r;
  logic [1:0] age_r;
  logic [6:0] low_r;
  logic [2:0] high_r;
  wire cfg_wr = wr_i && (addr_i == `UAXT_ADDR_CFG);
  wire act = (txd_i == inv_r);
  // txd trails an inversion write by a stage or two, so skip those cycles
  wire calm = (age_r == 2'h3);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) inv_r <= 1'b0;
    else if (cfg_wr) inv_r <= wdata_i[`UAXT_CFG_INV];
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) age_r <= 2'h3;
    else if (cfg_wr) age_r <= 2'h0;
    else if (!calm) age_r <= age_r + 2'h1;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) low_r <= 7'h00;
    else if (!act) low_r <= 7'h00;
    else if (low_r != 7'h7F) low_r <= low_r + 7'h01;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) high_r <= 3'h0;
    else if (act) high_r <= 3'h0;
    else if (high_r != 3'h7) high_r <= high_r + 3'h1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  reset_idle_a: assert property ($fell(rst_i) |-> txd_i && !txd_oe_i)
    else $error("line not idle after reset");
  // the pin flop adds a stage after the shifter, so the tick is two samples back
  tick_only_a: assert property ($changed(txd_i) && calm |-> $past(baud_tick_i, 2))
    else $error("line moved without a baud tick");
  bit_hold_a: assert property ($changed(txd_i) && calm |=> $stable(txd_i) [*3])
    else $error("bit shorter than four clocks");
  tick_period_a: assert property (baud_tick_i |=> !baud_tick_i [*3] ##1 baud_tick_i)
    else $error("baud tick period not four clocks");
  release_late_a: assert property ($fell(txd_oe_i) |-> high_r >= 3'h4)
    else $error("pin released before stop bit ended");
  break_max_a: assert property (low_r <= 7'h3C)
    else $error("active low run too long");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_i == 8'h00)
    else $error("read data outside answer cycle");
  oe_active_a: assert property (act && calm |-> txd_oe_i)
    else $error("line active while pin released");
endmodule : uaxt_link_assertions

// File: tb/tb.sv
// Purpose: self-checking bench, transmitter facing the remote receiver
// Assumes: divisor 4, so one bit is four clocks
// Notes: line sampled on falling edges where it has settled
`timescale 1ns/1ps
`include "uaxt_cfg.svh"
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rx_data_i = 8'h5A;
  logic nine_r = 1'b0;
  logic inv_r = 1'b0;
  logic [7:0] rdata_o;
  logic rx_data_read_o;
  logic baud_tick_o;
  logic valid_o;
  logic ferr_o;
  logic brk_o;
  logic [8:0] data_o;
  logic [7:0] rd_v;
  logic [7:0] c;
  int n_errors = 0;
  int checks = 0;
  int cnt;
  int n;
  uaxt_link_if link();
  always #25 ref_clk_i = ~ref_clk_i;
  uaxt_tx_dev uaxt_tx_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rx_data_i(rx_data_i),
    .rdata_o(rdata_o), .rx_data_read_o(rx_data_read_o), .baud_tick_o(baud_tick_o));
  uaxt_rx_rmt uaxt_rx_rmt_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .div_i(13'h0004), .nine_i(nine_r), .invert_i(inv_r), .data_o(data_o),
    .valid_o(valid_o), .framing_error_flag_o(ferr_o), .break_o(brk_o));
  uaxt_link_assertions uaxt_link_assertions_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .txd_i(link.txd), .txd_oe_i(link.txd_oe), .baud_tick_i(baud_tick_o), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_i(rdata_o));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask : rd
  task automatic poll(input int b);
    for (cnt = 0; cnt < 400; cnt++) begin
      rd(`UAXT_ADDR_STAT);
      if (rd_v[b] === 1'b1) break;
    end
    chk("status poll", 9'(cnt < 400), 9'h001);
    if (cnt == 400) end_sim();
  endtask : poll
  // a frame is whole once its valid pulse has shown
  task automatic rxw(input logic [8:0] exp);
    for (cnt = 0; cnt < 300 && valid_o !== 1'b1; cnt++) @(negedge ref_clk_i);
    chk("rx wait", 9'(cnt < 300), 9'h001);
    if (cnt == 300) end_sim();
    chk("rx data", data_o, exp);
    @(negedge ref_clk_i);
  endtask : rxw
  // counts clocks until the line next goes to its active-low level
  task automatic to_low();
    for (n = 0; n < 300 && link.txd !== inv_r; n++) @(negedge ref_clk_i);
    chk("line low wait", 9'(n < 300), 9'h001);
    if (n == 300) end_sim();
  endtask : to_low
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`UAXT_ADDR_STAT);
    chk("status reset", rd_v, 8'hC0);
    rd(`UAXT_ADDR_CFG);
    chk("cfg reset", rd_v, 8'h00);
    chk("txd reset", link.txd, 1'b1);
    chk("oe reset", link.txd_oe, 1'b0);
    rd(`UAXT_ADDR_DATA);
    chk("data read", rd_v, 8'h5A);
    chk("rx read pulse", rx_data_read_o, 1'b1);
    rd(3'h7);
    chk("unmapped", rd_v, 8'h00);
    $display("test reset done");
    wr(`UAXT_ADDR_DIVL, 8'h04);
    wr(`UAXT_ADDR_CTRL, 8'h08);
    wr(`UAXT_ADDR_DATA, 8'h55);
    rd(`UAXT_ADDR_STAT);
    chk("buffer full", rd_v[7], 1'b0);
    chk("oe on", link.txd_oe, 1'b1);
    poll(7);
    wr(`UAXT_ADDR_DATA, 8'hA3);
    rxw(9'h055);
    rxw(9'h0A3);
    poll(6);
    chk("txd idle", link.txd, 1'b1);
    $display("test data done");
    wr(`UAXT_ADDR_CTRL, 8'h18);
    nine_r <= 1'b1;
    wr(`UAXT_ADDR_CFG, 8'h40);
    wr(`UAXT_ADDR_DATA, 8'h81);
    rxw(9'h181);
    poll(6);
    wr(`UAXT_ADDR_CFG, 8'h00);
    $display("test nine bit done");
    for (int i = 0; i < 4; i++) begin
      c = {3'h0, i[0], 1'b1, i[1], 2'h0};
      poll(7);
      wr(`UAXT_ADDR_CTRL, c | 8'h01);
      nine_r <= i[0];
      wr(`UAXT_ADDR_CTRL, c);
      to_low();
      to_low();
      for (n = 0; n < 300 && link.txd === inv_r; n++) @(negedge ref_clk_i);
      chk("break len", 9'(n), 9'(40 + 4 * i[0] + 12 * i[1]));
      // the far end reports no later than a few clocks after the line returns high
      repeat (8) @(negedge ref_clk_i);
      chk("break data", data_o, 9'h000);
      chk("break seen", brk_o, 1'b1);
      chk("break framing", ferr_o, 1'b1);
      poll(6);
    end
    wr(`UAXT_ADDR_CTRL, 8'h08);
    nine_r <= 1'b0;
    $display("test break done");
    wr(`UAXT_ADDR_CFG, 8'h10);
    inv_r <= 1'b1;
    repeat (60) @(negedge ref_clk_i);
    chk("idle inverted", link.txd, 1'b0);
    wr(`UAXT_ADDR_DATA, 8'h3C);
    rxw(9'h03C);
    poll(6);
    wr(`UAXT_ADDR_CFG, 8'h00);
    inv_r <= 1'b0;
    repeat (60) @(negedge ref_clk_i);
    $display("test inversion done");
    wr(`UAXT_ADDR_DATA, 8'h0F);
    to_low();
    wr(`UAXT_ADDR_CTRL, 8'h00);
    for (n = 0; n < 300 && link.txd_oe === 1'b1; n++) @(negedge ref_clk_i);
    chk("oe held", 9'(n >= 30 && n < 300), 9'h001);
    rxw(9'h00F);
    chk("oe released", link.txd_oe, 1'b0);
    wr(`UAXT_ADDR_CTRL, 8'h08);
    wr(`UAXT_ADDR_DATA, 8'hC3);
    to_low();
    chk("preamble", 9'(n >= 36 && n < 300), 9'h001);
    rxw(9'h0C3);
    $display("test enable done");
    end_sim();
  end
endmodule : tb
